// ---- design/mopres_defines.svh ----
`ifndef MOPRES_DEFINES_SVH
`define MOPRES_DEFINES_SVH

// Register addresses
`define MOPRES_A_WAKE 8'h1B
`define MOPRES_A_STATUS 8'h1E
`define MOPRES_A_TEMP_L 8'h20
`define MOPRES_A_TEMP_H 8'h21
`define MOPRES_A_GX_L 8'h22
`define MOPRES_A_GX_H 8'h23
`define MOPRES_A_GY_L 8'h24
`define MOPRES_A_GY_H 8'h25
`define MOPRES_A_GZ_L 8'h26
`define MOPRES_A_GZ_H 8'h27
`define MOPRES_A_AX_L 8'h28
`define MOPRES_A_AX_H 8'h29
`define MOPRES_A_AY_L 8'h2A
`define MOPRES_A_AY_H 8'h2B
`define MOPRES_A_AZ_L 8'h2C
`define MOPRES_A_AZ_H 8'h2D
`define MOPRES_A_Q_L 8'h3E
`define MOPRES_A_Q_H 8'h3F
`define MOPRES_A_FUNC 8'h53
`define MOPRES_A_ORIENT 8'h0B
`define MOPRES_A_CTRL3 8'h12
`define MOPRES_A_CTRL5 8'h14
`define MOPRES_A_CTRL6 8'h15
`define MOPRES_A_CTRL7 8'h16

// Field positions
`define MOPRES_B_ORDER 1
`define MOPRES_B_ROUND_SRC 2
`define MOPRES_F_WRAP 2:0
`define MOPRES_F_DEN 7:5
`define MOPRES_F_MAP 2:0
`define MOPRES_B_NEG_X 5
`define MOPRES_B_NEG_Y 4
`define MOPRES_B_NEG_Z 3
`define MOPRES_M_ORIENT 8'h3F

// Field codes
`define MOPRES_WRAP_NONE 3'h0
`define MOPRES_WRAP_ACC 3'h1
`define MOPRES_WRAP_GYR 3'h2
`define MOPRES_WRAP_BOTH 3'h3
`define MOPRES_DEN_EDGE 3'h4
`define MOPRES_DEN_LEVEL 3'h2
`define MOPRES_DEN_PULSE 3'h3
`define MOPRES_MAP_XZY 3'h1
`define MOPRES_MAP_YXZ 3'h2
`define MOPRES_MAP_YZX 3'h3
`define MOPRES_MAP_ZXY 3'h4

// Reset values
`define MOPRES_R_BYTE 8'h00
`define MOPRES_R_WORD 16'h0000
`define MOPRES_R_SYNC 3'h0

`endif

// ---- design/mopres_pkg.sv ----
package mopres_pkg;

  typedef enum logic [1:0] {
    DEN_OFF = 2'h0,
    DEN_EDGE = 2'h1,
    DEN_LEVEL = 2'h3,
    DEN_PULSE = 2'h2
  } mopres_den_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } mopres_axes_t;

  typedef struct packed {
    logic [7:0] wake;
    logic [7:0] status;
    logic [7:0] func;
    logic [15:0] queue;
  } mopres_src_t;

  typedef struct packed {
    logic [7:0] ctrl3;
    logic [7:0] ctrl5;
    logic [7:0] ctrl6;
    logic [7:0] ctrl7;
    logic [7:0] orient;
  } mopres_cfg_t;

  typedef struct packed {
    logic [2:0] sync;
    logic external_data_gate;
    logic armed;
    logic pulse;
    mopres_cfg_t cfg;
    mopres_axes_t gyro;
    mopres_axes_t acc;
    logic [15:0] temp;
    logic [7:0] ptr;
    logic [7:0] rdata;
  } mopres_state_t;

endpackage

// ---- design/mopres_top.sv ----
`timescale 1ns/1ps
`include "mopres_defines.svh"
// Overview of operation
// - Each axis sample is 16 bits split over a high and low byte register.
// - The joined high and low bytes form a two's-complement signed value.
// - Order bit 0 (reset): low byte at lower address, high byte above.
// - Order bit 1: high byte at lower address, low byte above.
// - The swap applies alike to gyro, accel and temperature pairs.
// - Gyro bytes sit at 22h..27h as XL XH YL YH ZL ZH, one wrap group.
// - Accel bytes sit at 28h..2Dh as XL XH YL YH ZL ZH, one wrap group.
// - An enabled wrap burst runs first to last register, then back to first.
// - Bursts over the queue pair 3Eh/3Fh always wrap, no enable needed.
// - Source wrap bit set: burst runs status up to 53h, then back to 1Bh.
// - Wrap field: 000 none, 001 accel, 010 gyro, 011 gyro plus accel.
// - Gate bits reset to 0; 100 edge, 010 level, 011 pulse mode.
// - Any gate mode turns the second event pin into the gate input.
// - Edge mode loads gyro data only on the sample after a rising edge.
// - Level mode writes the gate level into each gyro sample LSB.
// - Pulse mode sets gyro LSB 1 after a pulse, else clears it to 0.
// - Orientation register: map in 2:0, signs X Y Z in 5 4 3, 7:6 zero.
// - Map codes 000..100 route pitch, roll, yaw onto X, Y, Z outputs.
// - A sign bit of 1 negates that gyro axis; 0 leaves it.
module mopres_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Sensor samples
  input mopres_pkg::mopres_axes_t gyro_raw,
  input wire logic gyro_valid,
  input mopres_pkg::mopres_axes_t accel_raw,
  input wire logic accel_valid,
  input wire logic [15:0] temp_raw,
  input wire logic temp_valid,
  input mopres_pkg::mopres_src_t src,
  // Register port
  input wire logic rd_start,
  input wire logic rd_next,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] rd_ptr,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Second event pin
  input wire logic event_level,
  input wire logic second_event_pin_i,
  output logic second_event_pin_o,
  output logic second_event_pin_oe
);

  mopres_pkg::mopres_state_t s;
  mopres_pkg::mopres_state_t next_s;
  mopres_pkg::mopres_den_t mode;
  mopres_pkg::mopres_axes_t g_map;
  mopres_pkg::mopres_axes_t g_out;
  logic rise;
  logic lsb;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic mopres_pkg::mopres_den_t den_mode(input logic [7:0] c6);
    case (c6[`MOPRES_F_DEN])
      `MOPRES_DEN_EDGE: den_mode = mopres_pkg::DEN_EDGE;
      `MOPRES_DEN_LEVEL: den_mode = mopres_pkg::DEN_LEVEL;
      `MOPRES_DEN_PULSE: den_mode = mopres_pkg::DEN_PULSE;
      default: den_mode = mopres_pkg::DEN_OFF;
    endcase
  endfunction

  // Byte of a pair; even address holds low byte unless swapped
  function automatic logic [7:0] pair_byte(input logic [15:0] w,
                                           input logic a0,
                                           input logic swap);
    if (a0 ^ swap) begin
      pair_byte = w[15:8];
    end else begin
      pair_byte = w[7:0];
    end
  endfunction

  function automatic logic [7:0] next_addr(input logic [7:0] a,
                                           input mopres_pkg::mopres_cfg_t c);
    logic [2:0] w;
    w = c.ctrl5[`MOPRES_F_WRAP];
    next_addr = a + 8'h01;
    if (a == `MOPRES_A_Q_H) begin
      next_addr = `MOPRES_A_Q_L;
    end else if (c.ctrl7[`MOPRES_B_ROUND_SRC] && a == `MOPRES_A_FUNC) begin
      next_addr = `MOPRES_A_WAKE;
    end else if (a == `MOPRES_A_GZ_H && w == `MOPRES_WRAP_GYR) begin
      next_addr = `MOPRES_A_GX_L;
    end else if (a == `MOPRES_A_AZ_H && w == `MOPRES_WRAP_ACC) begin
      next_addr = `MOPRES_A_AX_L;
    end else if (a == `MOPRES_A_AZ_H && w == `MOPRES_WRAP_BOTH) begin
      next_addr = `MOPRES_A_GX_L;
    end
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] a,
                                           input mopres_pkg::mopres_state_t st,
                                           input mopres_pkg::mopres_src_t sr);
    logic sw;
    sw = st.cfg.ctrl3[`MOPRES_B_ORDER];
    case (a)
      `MOPRES_A_WAKE: read_byte = sr.wake;
      `MOPRES_A_STATUS: read_byte = sr.status;
      `MOPRES_A_FUNC: read_byte = sr.func;
      `MOPRES_A_Q_L: read_byte = sr.queue[7:0];
      `MOPRES_A_Q_H: read_byte = sr.queue[15:8];
      `MOPRES_A_TEMP_L,
      `MOPRES_A_TEMP_H: read_byte = pair_byte(st.temp, a[0], sw);
      `MOPRES_A_GX_L,
      `MOPRES_A_GX_H: read_byte = pair_byte(st.gyro.x, a[0], sw);
      `MOPRES_A_GY_L,
      `MOPRES_A_GY_H: read_byte = pair_byte(st.gyro.y, a[0], sw);
      `MOPRES_A_GZ_L,
      `MOPRES_A_GZ_H: read_byte = pair_byte(st.gyro.z, a[0], sw);
      `MOPRES_A_AX_L,
      `MOPRES_A_AX_H: read_byte = pair_byte(st.acc.x, a[0], sw);
      `MOPRES_A_AY_L,
      `MOPRES_A_AY_H: read_byte = pair_byte(st.acc.y, a[0], sw);
      `MOPRES_A_AZ_L,
      `MOPRES_A_AZ_H: read_byte = pair_byte(st.acc.z, a[0], sw);
      `MOPRES_A_ORIENT: read_byte = st.cfg.orient;
      `MOPRES_A_CTRL3: read_byte = st.cfg.ctrl3;
      `MOPRES_A_CTRL5: read_byte = st.cfg.ctrl5;
      `MOPRES_A_CTRL6: read_byte = st.cfg.ctrl6;
      `MOPRES_A_CTRL7: read_byte = st.cfg.ctrl7;
      default: read_byte = `MOPRES_R_BYTE;
    endcase
  endfunction

  function automatic logic [15:0] signed_word(input logic [15:0] v,
                                              input logic neg);
    signed_word = neg ? 16'(~v + 16'h0001) : v;
  endfunction

  // ------------------------------------------------------------
  // Gyro path
  // ------------------------------------------------------------
  always_comb begin
    mode = den_mode(s.cfg.ctrl6);
    // Rising edge once second and third stages agree
    rise = (s.sync[1] == s.sync[2]) && s.sync[2] && !s.external_data_gate;
    g_map = gyro_raw;
    case (s.cfg.orient[`MOPRES_F_MAP])
      `MOPRES_MAP_XZY: begin
        g_map.y = gyro_raw.z;
        g_map.z = gyro_raw.y;
      end
      `MOPRES_MAP_YXZ: begin
        g_map.x = gyro_raw.y;
        g_map.y = gyro_raw.x;
      end
      `MOPRES_MAP_YZX: begin
        g_map.x = gyro_raw.z;
        g_map.y = gyro_raw.x;
        g_map.z = gyro_raw.y;
      end
      `MOPRES_MAP_ZXY: begin
        g_map.x = gyro_raw.y;
        g_map.y = gyro_raw.z;
        g_map.z = gyro_raw.x;
      end
      default: g_map = gyro_raw;
    endcase
    g_out.x = signed_word(g_map.x, s.cfg.orient[`MOPRES_B_NEG_X]);
    g_out.y = signed_word(g_map.y, s.cfg.orient[`MOPRES_B_NEG_Y]);
    g_out.z = signed_word(g_map.z, s.cfg.orient[`MOPRES_B_NEG_Z]);
    lsb = (mode == mopres_pkg::DEN_LEVEL) ? s.external_data_gate : (s.pulse | rise);
    if (mode == mopres_pkg::DEN_LEVEL || mode == mopres_pkg::DEN_PULSE) begin
      g_out.x[0] = lsb;
      g_out.y[0] = lsb;
      g_out.z[0] = lsb;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], second_event_pin_i};
    if (s.sync[1] == s.sync[2]) begin
      next_s.external_data_gate = s.sync[2];
    end
    // Edge and pulse memory, the clear on gyro_valid beats a new edge
    next_s.armed = (mode == mopres_pkg::DEN_EDGE) && (s.armed | rise) && !gyro_valid;
    next_s.pulse = (mode == mopres_pkg::DEN_PULSE) && (s.pulse | rise) && !gyro_valid;
    if (gyro_valid) begin
      if (mode != mopres_pkg::DEN_EDGE || s.armed || rise) begin
        next_s.gyro = g_out;
      end
    end
    if (accel_valid) begin
      next_s.acc = accel_raw;
    end
    if (temp_valid) begin
      next_s.temp = temp_raw;
    end
    if (wr_en) begin
      case (wr_addr)
        `MOPRES_A_ORIENT: next_s.cfg.orient = wr_data & `MOPRES_M_ORIENT;
        `MOPRES_A_CTRL3: next_s.cfg.ctrl3 = wr_data;
        `MOPRES_A_CTRL5: next_s.cfg.ctrl5 = wr_data;
        `MOPRES_A_CTRL6: next_s.cfg.ctrl6 = wr_data;
        `MOPRES_A_CTRL7: next_s.cfg.ctrl7 = wr_data;
        default: next_s.cfg = s.cfg;
      endcase
    end
    if (rd_start) begin
      next_s.rdata = read_byte(rd_addr, s, src);
      next_s.ptr = next_addr(rd_addr, s.cfg);
    end else if (rd_next) begin
      next_s.rdata = read_byte(s.ptr, s, src);
      next_s.ptr = next_addr(s.ptr, s.cfg);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s.sync <= `MOPRES_R_SYNC;
      s.external_data_gate <= 1'b0;
      s.armed <= 1'b0;
      s.pulse <= 1'b0;
      s.cfg <= '0;
      s.gyro <= '0;
      s.acc <= '0;
      s.temp <= `MOPRES_R_WORD;
      s.ptr <= `MOPRES_R_BYTE;
      s.rdata <= `MOPRES_R_BYTE;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rd_data = s.rdata;
  assign rd_ptr = s.ptr;
  assign second_event_pin_o = event_level;
  assign second_event_pin_oe = (mode == mopres_pkg::DEN_OFF);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  queue_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_Q_H |=> s.ptr == `MOPRES_A_Q_L)
    else $error("queue pair did not wrap");

  source_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_FUNC && s.cfg.ctrl7[`MOPRES_B_ROUND_SRC]
    |=> s.ptr == `MOPRES_A_WAKE)
    else $error("source group did not wrap");

  gyro_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_GZ_H
    && s.cfg.ctrl5[`MOPRES_F_WRAP] == `MOPRES_WRAP_GYR |=> s.ptr == `MOPRES_A_GX_L)
    else $error("gyro group did not wrap");

  accel_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_AZ_H
    && s.cfg.ctrl5[`MOPRES_F_WRAP] == `MOPRES_WRAP_ACC |=> s.ptr == `MOPRES_A_AX_L)
    else $error("accel group did not wrap");

  pin_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
    second_event_pin_oe == (s.cfg.ctrl6[`MOPRES_F_DEN] != `MOPRES_DEN_EDGE
    && s.cfg.ctrl6[`MOPRES_F_DEN] != `MOPRES_DEN_LEVEL
    && s.cfg.ctrl6[`MOPRES_F_DEN] != `MOPRES_DEN_PULSE))
    else $error("pin direction wrong");

  edge_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_EDGE && !s.armed && !rise && !wr_en |=> $stable(s.gyro))
    else $error("gyro updated without edge");

  level_lsb_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_LEVEL && gyro_valid && !wr_en
    |=> s.gyro.x[0] == $past(s.external_data_gate) && s.gyro.z[0] == $past(s.external_data_gate))
    else $error("level stamp wrong");

  swap_read_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_start && rd_addr == `MOPRES_A_GX_L && s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.gyro.x[15:8]))
    else $error("byte swap wrong");

  orient_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    (s.cfg.orient & ~`MOPRES_M_ORIENT) == `MOPRES_R_BYTE)
    else $error("orientation top bits set");

  plain_low_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_start && rd_addr == `MOPRES_A_GX_L && !s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.gyro.x[7:0]))
    else $error("low byte not at lower address");

  plain_high_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_start && rd_addr == `MOPRES_A_GX_H && !s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.gyro.x[15:8]))
    else $error("high byte not at upper address");

  swap_high_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_start && rd_addr == `MOPRES_A_GX_H && s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.gyro.x[7:0]))
    else $error("swapped upper byte wrong");

  temp_swap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_start && rd_addr == `MOPRES_A_TEMP_L && s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.temp[15:8]))
    else $error("temperature swap wrong");

  accel_swap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_AX_L && s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.acc.x[15:8]))
    else $error("accel swap wrong");

  gyro_step_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_GY_L && !s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.gyro.y[7:0]) && s.ptr == `MOPRES_A_GY_H)
    else $error("gyro burst step wrong");

  accel_z_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_AZ_H && !s.cfg.ctrl3[`MOPRES_B_ORDER]
    |=> rd_data == $past(s.acc.z[15:8]))
    else $error("accel z high byte wrong");

  both_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_AZ_H
    && s.cfg.ctrl5[`MOPRES_F_WRAP] == `MOPRES_WRAP_BOTH |=> s.ptr == `MOPRES_A_GX_L)
    else $error("joint group did not wrap");

  no_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd_next && !rd_start && s.ptr == `MOPRES_A_GZ_H
    && s.cfg.ctrl5[`MOPRES_F_WRAP] == `MOPRES_WRAP_NONE |=> s.ptr == `MOPRES_A_AX_L)
    else $error("burst wrapped without enable");

  edge_arm_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_EDGE && rise && !gyro_valid |=> s.armed)
    else $error("edge not remembered");

  edge_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_EDGE && gyro_valid && (s.armed || rise)
    |=> s.gyro == $past(g_out))
    else $error("gyro not loaded after edge");

  pulse_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_PULSE && rise && !gyro_valid |=> s.pulse)
    else $error("pulse not remembered");

  pulse_lsb_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_PULSE && gyro_valid
    |=> s.gyro.y[0] == $past(s.pulse || rise))
    else $error("pulse stamp wrong");

  pulse_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
    gyro_valid |=> !s.pulse)
    else $error("pulse memory not cleared");

  gate_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_OFF |=> !s.armed && !s.pulse)
    else $error("gate memory active while off");

  off_plain_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == mopres_pkg::DEN_OFF && gyro_valid && s.cfg.orient == `MOPRES_R_BYTE
    |=> s.gyro == $past(gyro_raw))
    else $error("gyro altered while gate off");

  map_yzx_a: assert property (@(posedge mclk) disable iff (!rstn)
    s.cfg.orient[`MOPRES_F_MAP] == `MOPRES_MAP_YZX
    |-> g_map.x == gyro_raw.z && g_map.y == gyro_raw.x && g_map.z == gyro_raw.y)
    else $error("axis map three wrong");

  map_zxy_a: assert property (@(posedge mclk) disable iff (!rstn)
    s.cfg.orient[`MOPRES_F_MAP] == `MOPRES_MAP_ZXY
    |-> g_map.x == gyro_raw.y && g_map.y == gyro_raw.z && g_map.z == gyro_raw.x)
    else $error("axis map four wrong");

  negate_x_a: assert property (@(posedge mclk) disable iff (!rstn)
    s.cfg.orient[`MOPRES_B_NEG_X] && mode == mopres_pkg::DEN_OFF
    |-> 16'(g_out.x + g_map.x) == `MOPRES_R_WORD)
    else $error("negated axis not opposite");

  keep_sign_a: assert property (@(posedge mclk) disable iff (!rstn)
    !s.cfg.orient[`MOPRES_B_NEG_Z] && mode == mopres_pkg::DEN_OFF
    |-> g_out.z == g_map.z)
    else $error("axis sign changed");

endmodule

// ---- dv/mopres_host.sv ----
`timescale 1ns/1ps
// -----------------------------
// Host reading over the port
// -----------------------------
module mopres_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic rd_start,
  output logic rd_next,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rd_ptr,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // Second event pin
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i
);
  logic gate;
  logic [7:0] bq[16];
  logic [7:0] pq[16];
  // Gate level reaches the pin only once the device lets go of it
  assign pin_i = pin_oe ? pin_o : gate;
  initial begin
    rd_start = 1'b0;
    rd_next = 1'b0;
    rd_addr = 8'h00;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    gate = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask
  // Back-to-back burst, one byte a cycle
  task burst(input logic [7:0] a, input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge mclk);
      if (i > 0) begin
        bq[i-1] = rd_data;
        pq[i-1] = rd_ptr;
      end
      rd_start = (i == 0);
      rd_next = (i > 0 && i < n);
      rd_addr = a;
    end
  endtask
  task set_gate(input logic v, input int hold);
    gate = v;
    repeat (hold) @(negedge mclk);
  endtask
endmodule

// ---- dv/motion_output_data_presenter_test.sv ----
`timescale 1ns/1ps
`include "mopres_defines.svh"
module motion_output_data_presenter_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  mopres_pkg::mopres_axes_t gyro_raw, accel_raw, eg;
  mopres_pkg::mopres_src_t src;
  logic gyro_valid, accel_valid, temp_valid, event_level;
  logic [15:0] temp_raw;
  logic rd_start, rd_next, wr_en, pin_i, pin_o, pin_oe;
  logic [7:0] rd_addr, rd_data, rd_ptr, wr_addr, wr_data, orient, ctl3;
  logic [95:0] cat;
  integer seed = 70;
  int err_count = 0;
  int n_compared = 0;

  always #10 mclk = ~mclk;

  mopres_top u_dut (.mclk(mclk), .rstn(rstn), .gyro_raw(gyro_raw), .gyro_valid(gyro_valid),
    .accel_raw(accel_raw), .accel_valid(accel_valid), .temp_raw(temp_raw),
    .temp_valid(temp_valid), .src(src), .rd_start(rd_start), .rd_next(rd_next),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ptr(rd_ptr), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .event_level(event_level), .second_event_pin_i(pin_i),
    .second_event_pin_o(pin_o), .second_event_pin_oe(pin_oe));
  mopres_host u_host (.mclk(mclk), .rd_start(rd_start), .rd_next(rd_next), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ptr(rd_ptr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

  // ---------------------
  // Expectation helpers
  // ---------------------
  function automatic mopres_pkg::mopres_axes_t xform(mopres_pkg::mopres_axes_t r,
                                                     logic [7:0] o);
    logic [15:0] p[3];
    logic [15:0] q[3];
    logic [5:0] d;
    p[0] = r.x;
    p[1] = r.y;
    p[2] = r.z;
    case (o[2:0])
      3'h1: d = 6'h18;
      3'h2: d = 6'h21;
      3'h3: d = 6'h09;
      3'h4: d = 6'h12;
      default: d = 6'h24;
    endcase
    for (int i = 0; i < 3; i++) q[d[2*i+:2]] = p[i];
    if (o[5]) q[0] = -q[0];
    if (o[4]) q[1] = -q[1];
    if (o[3]) q[2] = -q[2];
    return {q[0], q[1], q[2]};
  endfunction
  function automatic mopres_pkg::mopres_axes_t stamp(mopres_pkg::mopres_axes_t a, logic b);
    a.x[0] = b;
    a.y[0] = b;
    a.z[0] = b;
    return a;
  endfunction
  function automatic logic [7:0] bsel(logic [15:0] w, logic odd, logic swap);
    return (odd ^ swap) ? w[15:8] : w[7:0];
  endfunction
  function automatic logic [7:0] nxt(logic [7:0] a, logic [2:0] w, logic s);
    if (a == 8'h3F) return 8'h3E;
    if (a == 8'h53 && s) return 8'h1B;
    if (a == 8'h27 && w == 3'h2) return 8'h22;
    if (a == 8'h2D && w == 3'h1) return 8'h28;
    if (a == 8'h2D && w == 3'h3) return 8'h22;
    return a + 8'h01;
  endfunction

  // ------------------
  // Checks and close
  // ------------------
  task chk8(input logic [7:0] g, input logic [7:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task chk1(input logic g, input logic e, input string what);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, g, e);
    end
  endtask
  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task sample(input logic corner);
    @(negedge mclk);
    gyro_raw = 48'({$random(seed), $random(seed)});
    if (corner) gyro_raw = {16'h8000, 16'h7FFF, 16'h0001};
    accel_raw = 48'({$random(seed), $random(seed)});
    temp_raw = 16'($random(seed));
    src = 40'({$random(seed), $random(seed)});
    gyro_valid = 1'b1;
    accel_valid = 1'b1;
    temp_valid = 1'b1;
    @(negedge mclk);
    gyro_valid = 1'b0;
    accel_valid = 1'b0;
    temp_valid = 1'b0;
  endtask
  task chk_gyro;
    u_host.burst(`MOPRES_A_GX_L, 6);
    for (int i = 0; i < 6; i++) begin
      chk8(u_host.bq[i], bsel(eg[47-16*(i/2)-:16], i[0], ctl3[1]), "gyro byte");
    end
  endtask
  task set_mode(input logic [7:0] v, input logic oe);
    u_host.wr(`MOPRES_A_CTRL6, v);
    chk1(pin_oe, oe, "pin enable");
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    close_out;
  end

  // ---------------
  // Main sequence
  // ---------------
  initial begin
    {gyro_raw, accel_raw, temp_raw, src} = '0;
    {gyro_valid, accel_valid, temp_valid, event_level, ctl3} = '0;
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    chk1(pin_oe, 1'b1, "reset pin enable");
    u_host.burst(`MOPRES_A_CTRL6, 1);
    chk8(u_host.bq[0], 8'h00, "reset gate bits");
    event_level = 1'b1;
    @(negedge mclk);
    chk1(pin_o, 1'b1, "pin output level");
    for (int k = 0; k < 8; k++) begin
      orient = 8'($random(seed));
      if (k < 5) orient[2:0] = 3'(k);
      ctl3 = (k < 2) ? 8'(k << 1) : 8'($random(seed)) & 8'h02;
      u_host.wr(`MOPRES_A_ORIENT, orient);
      u_host.wr(`MOPRES_A_CTRL3, ctl3);
      u_host.wr(`MOPRES_A_CTRL5, 8'h00);
      sample(k == 0);
      cat = {xform(gyro_raw, orient), accel_raw};
      u_host.burst(`MOPRES_A_GX_L, 12);
      for (int i = 0; i < 12; i++) begin
        chk8(u_host.bq[i], bsel(cat[95-16*(i/2)-:16], i[0], ctl3[1]), "data");
        chk8(u_host.pq[i], 8'(8'h23 + i), "pointer");
      end
      u_host.burst(`MOPRES_A_TEMP_L, 2);
      chk8(u_host.bq[0], bsel(temp_raw, 1'b0, ctl3[1]), "temp low");
      chk8(u_host.bq[1], bsel(temp_raw, 1'b1, ctl3[1]), "temp high");
      u_host.burst(`MOPRES_A_ORIENT, 1);
      chk8(u_host.bq[0], orient & 8'h3F, "orientation");
    end
    for (int w = 0; w < 4; w++) begin
      u_host.wr(`MOPRES_A_CTRL5, 8'(w));
      u_host.burst(`MOPRES_A_GZ_L, 3);
      chk8(u_host.pq[1], nxt(8'h27, 3'(w), 1'b0), "gyro wrap");
      u_host.burst(`MOPRES_A_AZ_L, 3);
      chk8(u_host.pq[1], nxt(8'h2D, 3'(w), 1'b0), "accel wrap");
    end
    u_host.wr(`MOPRES_A_CTRL7, 8'h04);
    u_host.burst(`MOPRES_A_Q_L, 3);
    for (int i = 0; i < 3; i++) begin
      chk8(u_host.bq[i], bsel(src.queue, i[0], 1'b0), "queue byte");
      chk8(u_host.pq[i], i[0] ? 8'h3E : 8'h3F, "queue wrap");
    end
    u_host.burst(8'h52, 3);
    chk8(u_host.pq[1], 8'h1B, "source wrap");
    chk8(u_host.bq[1], src.func, "function source");
    chk8(u_host.bq[2], src.wake, "wake source");
    u_host.burst(`MOPRES_A_STATUS, 1);
    chk8(u_host.bq[0], src.status, "status");
    u_host.wr(`MOPRES_A_CTRL7, 8'h00);
    u_host.burst(`MOPRES_A_FUNC, 1);
    chk8(u_host.pq[0], 8'h54, "no source wrap");
    ctl3 = 8'h00;
    u_host.wr(`MOPRES_A_CTRL3, ctl3);
    u_host.wr(`MOPRES_A_ORIENT, 8'h00);
    set_mode(8'h40, 1'b0);
    for (int lv = 0; lv < 2; lv++) begin
      u_host.set_gate(lv[0], 6);
      sample(1'b0);
      eg = stamp(xform(gyro_raw, 8'h00), lv[0]);
      chk_gyro;
    end
    u_host.set_gate(1'b0, 6);
    set_mode(8'h80, 1'b0);
    sample(1'b0);
    chk_gyro;
    u_host.set_gate(1'b1, 6);
    sample(1'b0);
    eg = xform(gyro_raw, 8'h00);
    chk_gyro;
    set_mode(8'h60, 1'b0);
    u_host.set_gate(1'b0, 6);
    u_host.set_gate(1'b1, 2);
    u_host.set_gate(1'b0, 6);
    sample(1'b0);
    eg = stamp(xform(gyro_raw, 8'h00), 1'b1);
    chk_gyro;
    sample(1'b0);
    eg = stamp(xform(gyro_raw, 8'h00), 1'b0);
    chk_gyro;
    set_mode(8'hE0, 1'b1);
    u_host.set_gate(1'b1, 6);
    sample(1'b0);
    eg = xform(gyro_raw, 8'h00);
    chk_gyro;
    close_out;
  end
endmodule
